// ---- hdl/timer_capture_compare_opm.v ----
// capture, compare, forced output and one pulse logic of a 16-bit timer
// assumes the counter, prescaler and pwm waveform live outside; the counter
// value arrives on counterValue in the clk domain and reloads on counterReload
//
// How it works
// RULE1 - active capture edge sets flag and latches counter into capture value
// RULE2 - capture flag interrupts only with enable set and cpu mask clear
// RULE3 - capture flag clears after status read then low byte access
// RULE4 - high byte read blocks capture and flag until low byte read
// RULE5 - in single pulse or pwm mode only channel 2 captures
// RULE6 - capture pins always feed detectors, even when driven as outputs
// RULE7 - one capture irq enable covers both capture channels
// RULE8 - each channel has its own edge select bit, in control 1 and 2
// RULE9 - compare match sets flag, drives level if enabled, may interrupt
// RULE10 - compare output latches are low during reset
// RULE11 - compare values are software read/write, reset to 8000h
// RULE12 - both compare values checked on every counter step
// RULE13 - compare flag clears after status read then low byte access
// RULE14 - high byte write inhibits compare until low byte written
// RULE15 - without pin enable, no level applied but interrupt still possible
// RULE16 - divide by 2 matches at value, others at value plus one
// RULE17 - force bit copies level to pin, no flag, no interrupt
// RULE18 - force bits ignored in single pulse or pwm mode
// RULE19 - single pulse select takes over capture 1 and compare 1
// RULE20 - pulse trigger reloads counter, drives level 2, sets flag, loads FFFDh
// RULE21 - single pulse compare 1 match drives level 1, ending the pulse
// RULE22 - flash timer variant has no capture 2, write-only compare 2, flags zero
// RULE23 - with both single pulse and pwm set, only pwm is active
// RULE24 - single pulse mode never sets compare flag 1; flag 2 still works
// RULE25 - compare pins hold the last applied level until changed
`timescale 1ns/1ps
`default_nettype none
`include "timer_cc_consts.vh"

module timer_capture_compare_opm #(
  parameter FLASH_VARIANT = 0
) (
  // clock and reset
  input  wire        clk,
  input  wire        reset,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  // rest of the timer
  input  wire [15:0] counterValue,
  input  wire        overflowFlag,
  input  wire        cpuIrqMask,
  output reg         counterReload,
  output wire [1:0]  timerClockSelect,
  output wire        pwmActive,
  output reg         timerIrq,
  // pins
  input  wire        capturePin1,
  input  wire        capturePin2,
  output reg         compareOutPin1,
  output reg         compareOutPin2,
  output wire        compareOutEn1,
  output wire        compareOutEn2
);

  // ****************************************************************
  // functions
  // ****************************************************************

  // compare hit: divide by 2 at value, slower clocks at value plus one
  function matchHit;
    input [15:0] cnt;
    input [15:0] cmp;
    input        div2;
    begin
      matchHit = div2 ? (cnt == cmp) : (cnt == cmp + 16'h0001); // [RULE16]
    end
  endfunction

  // ****************************************************************
  // registers
  // ****************************************************************
  reg  [7:0]  control1_reg;
  reg  [7:0]  control2_reg;
  reg  [15:0] capture1_reg;
  reg  [15:0] capture2_reg;
  reg  [15:0] compare1_reg;
  reg  [15:0] compare2_reg;
  reg         capFlag1_reg;
  reg         capFlag2_reg;
  reg         cmpFlag1_reg;
  reg         cmpFlag2_reg;
  reg         capArm1_reg;
  reg         capArm2_reg;
  reg         cmpArm1_reg;
  reg         cmpArm2_reg;
  reg         capBlock1_reg;
  reg         capBlock2_reg;
  reg         cmpInhibit1_reg;
  reg         cmpInhibit2_reg;
  reg  [15:0] lastCounter_reg;
  reg  [2:0]  sync1_reg;
  reg  [2:0]  sync2_reg;
  reg         stable1_reg;
  reg         stable2_reg;
  reg  [1:0]  fill_reg;

  // ****************************************************************
  // decode
  // ****************************************************************
  wire access   = psel & penable;
  wire wrAccess = access & pwrite;
  wire rdAccess = access & ~pwrite;

  wire hitCtl1  = (paddr == `OFS_CONTROL1);
  wire hitCtl2  = (paddr == `OFS_CONTROL2);
  wire hitStat  = (paddr == `OFS_STATUS);
  wire hitCap1H = (paddr == `OFS_CAP1_HIGH);
  wire hitCap1L = (paddr == `OFS_CAP1_LOW);
  wire hitCmp1H = (paddr == `OFS_CMP1_HIGH);
  wire hitCmp1L = (paddr == `OFS_CMP1_LOW);
  wire hitCap2H = (paddr == `OFS_CAP2_HIGH);
  wire hitCap2L = (paddr == `OFS_CAP2_LOW);
  wire hitCmp2H = (paddr == `OFS_CMP2_HIGH);
  wire hitCmp2L = (paddr == `OFS_CMP2_LOW);
  wire mapped   = hitCtl1 | hitCtl2 | hitStat | hitCap1H | hitCap1L | hitCmp1H |
                  hitCmp1L | hitCap2H | hitCap2L | hitCmp2H | hitCmp2L;

  // zero wait state slave, error on unmapped offsets
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  // ****************************************************************
  // modes
  // ****************************************************************
  wire pwmSel       = control2_reg[`C2_PWM];
  wire singlePulse  = control2_reg[`C2_SINGLE_PULSE] & ~pwmSel; // [RULE23]
  wire modeBusy     = singlePulse | pwmSel;
  wire div2         = (control2_reg[`C2_CLK_SEL_HI:`C2_CLK_SEL_LO] == `CLK_SEL_DIV2);
  wire level1       = control1_reg[`C1_OUT_LEVEL1];
  wire level2       = control1_reg[`C1_OUT_LEVEL2];
  wire pinEn1       = control2_reg[`C2_PIN_EN1];
  wire pinEn2       = control2_reg[`C2_PIN_EN2];

  assign pwmActive        = pwmSel;
  assign timerClockSelect = control2_reg[`C2_CLK_SEL_HI:`C2_CLK_SEL_LO];
  assign compareOutEn1    = pinEn1;
  assign compareOutEn2    = pinEn2;

  // ****************************************************************
  // capture pin synchronisers and edge detection
  // ****************************************************************

  // three stages; a change counts once stages two and three agree
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      sync1_reg   <= 3'h0;
      sync2_reg   <= 3'h0;
      stable1_reg <= 1'b0;
      stable2_reg <= 1'b0;
      fill_reg    <= 2'h0;
    end else begin
      sync1_reg <= {sync1_reg[1:0], capturePin1}; // [RULE6]
      sync2_reg <= {sync2_reg[1:0], capturePin2}; // [RULE6]
      if (fill_reg != 2'h3)
        fill_reg <= fill_reg + 2'h1; // stable follows the chain while it fills: no false edge after reset
      if ((fill_reg != 2'h3) | (sync1_reg[1] == sync1_reg[2]))
        stable1_reg <= sync1_reg[1];
      if ((fill_reg != 2'h3) | (sync2_reg[1] == sync2_reg[2]))
        stable2_reg <= sync2_reg[1];
    end
  end

  wire change1 = (sync1_reg[1] == sync1_reg[2]) & (sync1_reg[2] != stable1_reg);
  wire change2 = (sync2_reg[1] == sync2_reg[2]) & (sync2_reg[2] != stable2_reg);
  // edge select bit 1 picks rising, 0 falling
  wire edge1   = change1 & (sync1_reg[2] == control1_reg[`C1_CAP_EDGE1]); // [RULE8]
  wire edge2   = change2 & (sync2_reg[2] == control2_reg[`C2_CAP_EDGE2]); // [RULE8]

  // ****************************************************************
  // events
  // ****************************************************************
  wire newStep    = (counterValue != lastCounter_reg); // [RULE12]
  wire pulseStart = singlePulse & edge1; // [RULE19]
  wire capEvent1  = ~modeBusy & edge1 & ~capBlock1_reg; // [RULE5] [RULE4]
  wire capEvent2  = edge2 & ~capBlock2_reg & (FLASH_VARIANT == 0); // [RULE4] [RULE22]
  wire hit1       = newStep & ~cmpInhibit1_reg & matchHit(counterValue, compare1_reg, div2); // [RULE14]
  wire hit2       = newStep & ~cmpInhibit2_reg & matchHit(counterValue, compare2_reg, div2); // [RULE14]
  wire cmpEvent1  = hit1 & ~modeBusy; // [RULE24]
  wire cmpEvent2  = hit2 & ~pwmSel & (FLASH_VARIANT == 0); // [RULE22]
  wire forceOk    = wrAccess & hitCtl1 & ~modeBusy; // [RULE18]

  // ****************************************************************
  // control and compare value registers
  // ****************************************************************

  // force bits are write pulses and never stored
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      control1_reg    <= `CONTROL_RESET;
      control2_reg    <= `CONTROL_RESET;
      compare1_reg    <= `CMP_RESET_VALUE; // [RULE11]
      compare2_reg    <= `CMP_RESET_VALUE; // [RULE11]
      cmpInhibit1_reg <= 1'b0;
      cmpInhibit2_reg <= 1'b0;
      lastCounter_reg <= 16'h0000;
    end else begin
      lastCounter_reg <= counterValue;
      if (wrAccess & hitCtl1)
        control1_reg <= pwdata[7:0] & 8'hE7;
      if (wrAccess & hitCtl2)
        control2_reg <= pwdata[7:0];
      // only software touches the compare values
      if (wrAccess & hitCmp1H) begin
        compare1_reg[15:8] <= pwdata[7:0]; // [RULE11]
        cmpInhibit1_reg    <= 1'b1; // [RULE14]
      end
      if (wrAccess & hitCmp1L) begin
        compare1_reg[7:0]  <= pwdata[7:0];
        cmpInhibit1_reg    <= 1'b0; // [RULE14]
      end
      if (wrAccess & hitCmp2H) begin
        compare2_reg[15:8] <= pwdata[7:0];
        cmpInhibit2_reg    <= 1'b1; // [RULE14]
      end
      if (wrAccess & hitCmp2L) begin
        compare2_reg[7:0]  <= pwdata[7:0];
        cmpInhibit2_reg    <= 1'b0; // [RULE14]
      end
    end
  end

  // ****************************************************************
  // capture values and blocking
  // ****************************************************************

  // high byte read freezes the channel until its low byte is read
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      capture1_reg  <= 16'h0000;
      capture2_reg  <= 16'h0000;
      capBlock1_reg <= 1'b0;
      capBlock2_reg <= 1'b0;
    end else begin
      if (pulseStart)
        capture1_reg <= `PULSE_CAPTURE; // [RULE20]
      else if (capEvent1)
        capture1_reg <= counterValue; // [RULE1]
      if (capEvent2)
        capture2_reg <= counterValue; // [RULE1]
      if (rdAccess & hitCap1L)
        capBlock1_reg <= 1'b0;
      else if (rdAccess & hitCap1H)
        capBlock1_reg <= 1'b1; // [RULE4]
      if (rdAccess & hitCap2L)
        capBlock2_reg <= 1'b0;
      else if (rdAccess & hitCap2H)
        capBlock2_reg <= 1'b1; // [RULE4]
    end
  end

  // ****************************************************************
  // status flags with two step clear
  // ****************************************************************

  // a status read arms the clear; low byte access clears; a new event wins
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      capFlag1_reg <= 1'b0;
      capFlag2_reg <= 1'b0;
      cmpFlag1_reg <= 1'b0;
      cmpFlag2_reg <= 1'b0;
      capArm1_reg  <= 1'b0;
      capArm2_reg  <= 1'b0;
      cmpArm1_reg  <= 1'b0;
      cmpArm2_reg  <= 1'b0;
    end else begin
      if (rdAccess & hitStat & capFlag1_reg)
        capArm1_reg <= 1'b1;
      else if (access & hitCap1L)
        capArm1_reg <= 1'b0;
      if (rdAccess & hitStat & capFlag2_reg)
        capArm2_reg <= 1'b1;
      else if (access & hitCap2L)
        capArm2_reg <= 1'b0;
      if (rdAccess & hitStat & cmpFlag1_reg)
        cmpArm1_reg <= 1'b1;
      else if (access & hitCmp1L)
        cmpArm1_reg <= 1'b0;
      if (rdAccess & hitStat & cmpFlag2_reg)
        cmpArm2_reg <= 1'b1;
      else if (access & hitCmp2L)
        cmpArm2_reg <= 1'b0;

      if (capEvent1 | pulseStart)
        capFlag1_reg <= 1'b1; // [RULE1] [RULE20]
      else if (capArm1_reg & access & hitCap1L)
        capFlag1_reg <= 1'b0; // [RULE3]
      if (capEvent2)
        capFlag2_reg <= 1'b1; // [RULE1]
      else if (capArm2_reg & access & hitCap2L)
        capFlag2_reg <= 1'b0; // [RULE3]
      if (cmpEvent1)
        cmpFlag1_reg <= 1'b1; // [RULE9]
      else if (cmpArm1_reg & access & hitCmp1L)
        cmpFlag1_reg <= 1'b0; // [RULE13]
      if (cmpEvent2)
        cmpFlag2_reg <= 1'b1; // [RULE9] [RULE24]
      else if (cmpArm2_reg & access & hitCmp2L)
        cmpFlag2_reg <= 1'b0; // [RULE13]
    end
  end

  // ****************************************************************
  // compare output pins
  // ****************************************************************

  // latches hold their level until a match, pulse event or force
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      compareOutPin1 <= 1'b0; // [RULE10]
      compareOutPin2 <= 1'b0; // [RULE10]
      counterReload  <= 1'b0;
    end else begin
      counterReload <= pulseStart; // [RULE20]
      if (pulseStart & pinEn1)
        compareOutPin1 <= level2; // [RULE20]
      else if (singlePulse & hit1 & pinEn1)
        compareOutPin1 <= level1; // [RULE21]
      else if (cmpEvent1 & pinEn1)
        compareOutPin1 <= level1; // [RULE9] [RULE15]
      else if (forceOk & pwdata[`C1_FORCE1] & pinEn1)
        compareOutPin1 <= pwdata[`C1_OUT_LEVEL1]; // [RULE17]
      if (cmpEvent2 & pinEn2 & ~singlePulse)
        compareOutPin2 <= level2; // [RULE9] [RULE15]
      else if (forceOk & pwdata[`C1_FORCE2] & pinEn2)
        compareOutPin2 <= pwdata[`C1_OUT_LEVEL2]; // [RULE17] [RULE25]
    end
  end

  // ****************************************************************
  // shared timer interrupt
  // ****************************************************************

  // flags stay pending while masked; one enable for both captures
  always @(posedge clk or posedge reset) begin
    if (reset)
      timerIrq <= 1'b0;
    else
      timerIrq <= ~cpuIrqMask & // [RULE2]
                  ((control1_reg[`C1_CAP_IRQ_EN] & (capFlag1_reg | capFlag2_reg)) | // [RULE7]
                   (control1_reg[`C1_CMP_IRQ_EN] & (cmpFlag1_reg | cmpFlag2_reg)) | // [RULE9]
                   (control1_reg[`C1_OVF_IRQ_EN] & overflowFlag));
  end

  // ****************************************************************
  // read data
  // ****************************************************************

  // flash variant hides capture 2 and compare 2 from reads
  always @(posedge clk or posedge reset) begin
    if (reset)
      prdata <= 32'h00000000;
    else if (psel & ~penable & ~pwrite) begin
      prdata <= 32'h00000000;
      if (hitCtl1)
        prdata[7:0] <= control1_reg;
      if (hitCtl2)
        prdata[7:0] <= control2_reg;
      if (hitStat)
        prdata[7:0] <= {capFlag1_reg, cmpFlag1_reg, overflowFlag, capFlag2_reg, cmpFlag2_reg, 3'h0};
      if (hitCap1H)
        prdata[7:0] <= capture1_reg[15:8];
      if (hitCap1L)
        prdata[7:0] <= capture1_reg[7:0];
      if (hitCmp1H)
        prdata[7:0] <= compare1_reg[15:8];
      if (hitCmp1L)
        prdata[7:0] <= compare1_reg[7:0];
      if (hitCap2H & (FLASH_VARIANT == 0))
        prdata[7:0] <= capture2_reg[15:8]; // [RULE22]
      if (hitCap2L & (FLASH_VARIANT == 0))
        prdata[7:0] <= capture2_reg[7:0];
      if (hitCmp2H & (FLASH_VARIANT == 0))
        prdata[7:0] <= compare2_reg[15:8]; // [RULE22]
      if (hitCmp2L & (FLASH_VARIANT == 0))
        prdata[7:0] <= compare2_reg[7:0];
    end
  end

endmodule

`default_nettype wire

// ---- hdl/timer_cc_consts.vh ----
// constants for the timer capture / compare / one pulse block
// assumes an APB slave with byte offsets in paddr[7:0]
`ifndef TIMER_CC_CONSTS_VH
`define TIMER_CC_CONSTS_VH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define OFS_CONTROL1     8'h00
`define OFS_CONTROL2     8'h04
`define OFS_STATUS       8'h08
`define OFS_CAP1_HIGH    8'h0C
`define OFS_CAP1_LOW     8'h10
`define OFS_CMP1_HIGH    8'h14
`define OFS_CMP1_LOW     8'h18
`define OFS_CAP2_HIGH    8'h1C
`define OFS_CAP2_LOW     8'h20
`define OFS_CMP2_HIGH    8'h24
`define OFS_CMP2_LOW     8'h28

// ****************************************************************
// control register 1 bit positions
// ****************************************************************
`define C1_CAP_IRQ_EN    7
`define C1_CMP_IRQ_EN    6
`define C1_OVF_IRQ_EN    5
`define C1_FORCE2        4
`define C1_FORCE1        3
`define C1_OUT_LEVEL2    2
`define C1_CAP_EDGE1     1
`define C1_OUT_LEVEL1    0

// ****************************************************************
// control register 2 bit positions
// ****************************************************************
`define C2_PIN_EN1       7
`define C2_PIN_EN2       6
`define C2_SINGLE_PULSE  5
`define C2_PWM           4
`define C2_CLK_SEL_HI    3
`define C2_CLK_SEL_LO    2
`define C2_CAP_EDGE2     1
`define C2_EXT_EDGE      0

// ****************************************************************
// status register bit positions
// ****************************************************************
`define SR_CAP_FLAG1     7
`define SR_CMP_FLAG1     6
`define SR_OVF_FLAG      5
`define SR_CAP_FLAG2     4
`define SR_CMP_FLAG2     3

// ****************************************************************
// values
// ****************************************************************
`define CMP_RESET_VALUE  16'h8000
`define PULSE_CAPTURE    16'hFFFD
`define CLK_SEL_DIV2     2'h2
`define CONTROL_RESET    8'h00

`endif

// ---- testbench/tb.sv ----
// testbench: apb register sequences with pin and register checks
// assumes the partner model supplies the counter and the capture pins
`timescale 1ns/1ps
`default_nettype none
`include "timer_cc_consts.vh"

module tb;
  logic        clk;
  logic        reset;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic        cpuIrqMask;
  logic        cntRun;
  logic        cntSet;
  logic [15:0] cntVal;
  logic        lvl1;
  logic        lvl2;
  logic [7:0]  rdq;
  logic        errq;
  wire  [31:0] prdata;
  wire         pready;
  wire         pslverr;
  wire  [15:0] counterValue;
  wire         counterReload;
  wire         timerIrq;
  wire         capturePin1;
  wire         capturePin2;
  wire         pin1;
  int          error_cnt;
  int          n_checks;
  int          cycles;

  timer_capture_compare_opm i_dut (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .counterValue(counterValue), .overflowFlag(1'b0), .cpuIrqMask(cpuIrqMask), .counterReload(counterReload),
    .timerClockSelect(), .pwmActive(), .timerIrq(timerIrq), .capturePin1(capturePin1),
    .capturePin2(capturePin2), .compareOutPin1(pin1), .compareOutPin2(), .compareOutEn1(), .compareOutEn2());

  timer_cc_partner i_far (.clk(clk), .reset(reset), .run(cntRun), .setEn(cntSet), .setVal(cntVal),
    .level1(lvl1), .level2(lvl2), .counterReload(counterReload), .counterValue(counterValue),
    .capturePin1(capturePin1), .capturePin2(capturePin2));

  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      error_cnt++;
      end_of_test();
    end
  end

  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic end_of_test();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one apb transfer: setup, then access until pready
  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= {24'h000000, d};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rdq  = prdata[7:0];
    errq = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rc(input logic [7:0] a, input logic [7:0] e, input string nm);
    apb(1'b0, a, 8'h00);
    chk(nm, {8'h00, rdq}, {8'h00, e});
  endtask

  task automatic setCnt(input logic [15:0] v);
    cntSet <= 1'b1;
    cntVal <= v;
    @(posedge clk);
    cntSet <= 1'b0;
    @(posedge clk);
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    reset      = 1'b1;
    psel       = 1'b0;
    penable    = 1'b0;
    pwrite     = 1'b0;
    paddr      = 8'h00;
    pwdata     = 32'h00000000;
    cpuIrqMask = 1'b1;
    cntRun     = 1'b0;
    cntSet     = 1'b0;
    cntVal     = 16'h0000;
    lvl1       = 1'b0;
    lvl2       = 1'b1;
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    // reset values, readback, unmapped offset
    rc(`OFS_CMP1_HIGH, 8'h80, "cmp1 high");
    rc(`OFS_CMP2_LOW, 8'h00, "cmp2 low");
    chk("pin1", {15'h0000, pin1}, 16'h0000);
    wr(`OFS_CMP1_HIGH, 8'h12);
    wr(`OFS_CMP1_LOW, 8'h34);
    rc(`OFS_CMP1_HIGH, 8'h12, "cmp1 high");
    rc(8'h2C, 8'h00, "unmapped");
    chk("unmapped err", {15'h0000, errq}, 16'h0001);
    // channel 1 capture on a rising edge, masked first, then blocked
    setCnt(16'h4321);
    wr(`OFS_CONTROL1, 8'h82);
    lvl1 <= 1'b1;
    repeat (8) @(posedge clk);
    rc(`OFS_STATUS, 8'h80, "status");
    chk("irq masked", {15'h0000, timerIrq}, 16'h0000);
    cpuIrqMask <= 1'b0;
    repeat (3) @(posedge clk);
    chk("irq", {15'h0000, timerIrq}, 16'h0001);
    rc(`OFS_CAP1_HIGH, 8'h43, "cap1 high");
    setCnt(16'h5555);
    lvl1 <= 1'b0;
    repeat (2) @(posedge clk);
    lvl1 <= 1'b1;
    repeat (8) @(posedge clk);
    rc(`OFS_CAP1_LOW, 8'h21, "cap1 low");
    rc(`OFS_STATUS, 8'h00, "status");
    // channel 2 capture on a falling edge, same enable
    setCnt(16'hBEEF);
    lvl2 <= 1'b0;
    repeat (8) @(posedge clk);
    rc(`OFS_STATUS, 8'h10, "status");
    chk("irq ch2", {15'h0000, timerIrq}, 16'h0001);
    rc(`OFS_CAP2_HIGH, 8'hBE, "cap2 high");
    rc(`OFS_CAP2_LOW, 8'hEF, "cap2 low");
    rc(`OFS_STATUS, 8'h00, "status");
    // compare at divide by 2 matches the value itself
    wr(`OFS_CONTROL1, 8'h41);
    wr(`OFS_CONTROL2, 8'h88);
    setCnt(16'h1233);
    repeat (3) @(posedge clk);
    chk("pin1", {15'h0000, pin1}, 16'h0000);
    setCnt(16'h1234);
    repeat (3) @(posedge clk);
    chk("pin1", {15'h0000, pin1}, 16'h0001);
    chk("irq cmp", {15'h0000, timerIrq}, 16'h0001);
    rc(`OFS_STATUS, 8'h40, "status");
    rc(`OFS_CMP1_LOW, 8'h34, "cmp1 low");
    rc(`OFS_STATUS, 8'h00, "status");
    // slower clocks match one count later
    wr(`OFS_CONTROL1, 8'h40);
    wr(`OFS_CONTROL2, 8'h80);
    setCnt(16'h1233);
    setCnt(16'h1234);
    repeat (3) @(posedge clk);
    chk("pin1", {15'h0000, pin1}, 16'h0001);
    rc(`OFS_STATUS, 8'h00, "status");
    setCnt(16'h1235);
    repeat (3) @(posedge clk);
    chk("pin1", {15'h0000, pin1}, 16'h0000);
    rc(`OFS_STATUS, 8'h40, "status");
    rc(`OFS_CMP1_LOW, 8'h34, "cmp1 low");
    // forced level: pin moves, no flag, no interrupt
    wr(`OFS_CONTROL1, 8'h49);
    @(posedge clk);
    chk("pin1", {15'h0000, pin1}, 16'h0001);
    chk("irq force", {15'h0000, timerIrq}, 16'h0000);
    rc(`OFS_STATUS, 8'h00, "status");
    // single pulse: force ignored, trigger, pulse end
    wr(`OFS_CMP1_HIGH, 8'h00);
    wr(`OFS_CMP1_LOW, 8'h03);
    wr(`OFS_CONTROL2, 8'hA8);
    wr(`OFS_CONTROL1, 8'h0A);
    @(posedge clk);
    chk("pin1", {15'h0000, pin1}, 16'h0001);
    lvl1 <= 1'b0;
    repeat (6) @(posedge clk);
    wr(`OFS_CONTROL1, 8'h03);
    setCnt(16'h0100);
    cntRun <= 1'b1;
    lvl1   <= 1'b1;
    for (int i = 0; i < 10 && counterReload !== 1'b1; i++) @(posedge clk);
    chk("reload", {15'h0000, counterReload}, 16'h0001);
    repeat (2) @(posedge clk);
    chk("pin1 pulse", {15'h0000, pin1}, 16'h0000);
    repeat (12) @(posedge clk);
    chk("pin1 end", {15'h0000, pin1}, 16'h0001);
    cntRun <= 1'b0;
    rc(`OFS_STATUS, 8'h80, "status");
    rc(`OFS_CAP1_HIGH, 8'hFF, "cap1 high");
    rc(`OFS_CAP1_LOW, 8'hFD, "cap1 low");
    end_of_test();
  end
endmodule
`default_nettype wire

// ---- testbench/timer_cc_chk.sv ----
// checker: port timing relations of the timer capture/compare block
// assumes one clock domain and the offsets of the shared constants header
`timescale 1ns/1ps
`default_nettype none
`include "timer_cc_consts.vh"

module timer_cc_chk (
  // clock and reset
  input wire logic        clk,
  input wire logic        reset,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic        pslverr,
  // timer side
  input wire logic [15:0] counterValue,
  input wire logic        cpuIrqMask,
  input wire logic        counterReload,
  input wire logic [1:0]  timerClockSelect,
  input wire logic        timerIrq,
  // pins
  input wire logic        capturePin1,
  input wire logic        compareOutPin1,
  input wire logic        compareOutPin2
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  // ****************************************************************
  // cycles since anything that may move a compare pin
  // ****************************************************************
  logic [3:0] quiet;

  // restart on writes, counter steps and capturePin1 edges
  always_ff @(posedge clk or posedge reset) begin
    if (reset)
      quiet <= 4'h0;
    else if ((psel && penable && pwrite) || !$stable(counterValue) || !$stable(capturePin1))
      quiet <= 4'h0;
    else if (quiet != 4'hF)
      quiet <= quiet + 4'h1;
  end

  // reload request lasts exactly one cycle
  sequence pulseOne;
    counterReload ##1 !counterReload;
  endsequence

  unmapped_err_a: assert property (psel && penable && paddr > 8'h28 |-> pslverr)
    else $error("no error response at unmapped offset");
  mapped_ok_a: assert property (psel && penable && paddr <= 8'h28 && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("error response at mapped offset");
  reload_once_a: assert property ($rose(counterReload) |-> pulseOne)
    else $error("counter reload pulse too long");
  irq_masked_a: assert property (cpuIrqMask [*2] |-> !timerIrq)
    else $error("interrupt high while masked");
  irq_rise_a: assert property ($rose(timerIrq) |-> !$past(cpuIrqMask))
    else $error("interrupt rose under mask");
  pins_reset_a: assert property (disable iff (1'b0) reset |-> !compareOutPin1 && !compareOutPin2)
    else $error("compare pin high in reset");
  pins_hold_a: assert property (!$stable(compareOutPin1) || !$stable(compareOutPin2) |-> quiet <= 4'h7)
    else $error("compare pin moved without cause");
  clksel_write_a: assert property (!$stable(timerClockSelect) |-> $past(psel && penable && pwrite && paddr == 8'h04))
    else $error("clock select moved without write");
endmodule

bind timer_capture_compare_opm timer_cc_chk i_chk (.clk, .reset, .psel, .penable, .pwrite, .paddr, .pslverr,
  .counterValue, .cpuIrqMask, .counterReload, .timerClockSelect, .timerIrq, .capturePin1, .compareOutPin1,
  .compareOutPin2);
`default_nettype wire

// ---- testbench/timer_cc_partner.sv ----
// partner: counter of the timer core and the capture pin sources
// assumes the bench steers it through run, setEn and the pin levels
`timescale 1ns/1ps
`default_nettype none

module timer_cc_partner (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // steering from the bench
  input  wire logic        run,
  input  wire logic        setEn,
  input  wire logic [15:0] setVal,
  input  wire logic        level1,
  input  wire logic        level2,
  // block side
  input  wire logic        counterReload,
  output logic      [15:0] counterValue,
  output logic             capturePin1,
  output logic             capturePin2
);
  // counter: reload wins over a bench load and over counting
  always_ff @(posedge clk or posedge reset) begin
    if (reset)
      counterValue <= 16'hFFFC;
    else if (counterReload)
      counterValue <= 16'hFFFC;
    else if (setEn)
      counterValue <= setVal;
    else if (run)
      counterValue <= counterValue + 16'h0001;
  end

  // push-pull sources, so the pins always show a defined level
  assign capturePin1 = level1;
  assign capturePin2 = level2;
endmodule
`default_nettype wire
